// ### lpi_pkg.sv
// Constants shared by the memory pin interface: widths, command codes, timing.
// Assumes a single core clock that stands for the sampling crossing of the memory clock pair.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package lpi_pkg;
  localparam int LPI_ADDR_W = 13;
  localparam int LPI_BANK_W = 2;
  localparam int LPI_AP_BIT = 10;
  localparam int LPI_BURST_LEN = 4;
  localparam int LPI_READ_LAT = 2;
  localparam int LPI_FIFO_DEPTH = 8;
  localparam int LPI_MR_COUNT = 2;
  localparam logic [3:0] LPI_CMD_MRS = 4'h0;
  localparam logic [3:0] LPI_CMD_REF = 4'h1;
  localparam logic [3:0] LPI_CMD_PRE = 4'h2;
  localparam logic [3:0] LPI_CMD_ACT = 4'h3;
  localparam logic [3:0] LPI_CMD_WR = 4'h4;
  localparam logic [3:0] LPI_CMD_RD = 4'h5;
  localparam logic [3:0] LPI_CMD_BST = 4'h6;
  localparam logic [3:0] LPI_CMD_NOP = 4'h7;
  typedef enum logic [1:0] {
    LPI_ST_IDLE = 2'b00,
    LPI_ST_WRITE = 2'b01,
    LPI_ST_READ = 2'b10
  } lpi_state_type;
endpackage

// ### lpi_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module lpi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge core_clk) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data;
  end
endmodule
`default_nettype wire

// ### lpi_decode.sv
// Command decoder: chip select and the three strobes into one command code.
// Assumes inputs are already registered on the rising crossing.
`timescale 1ns/10ps
`default_nettype none
module lpi_decode
  import lpi_pkg::*;
(
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  output logic [3:0] cmd
);
  // Chip select high masks everything, whatever the strobes say.
  assign cmd = chip_select_n ? LPI_CMD_NOP :
               {1'b0, row_strobe_n, col_strobe_n, write_strobe_n};
endmodule
`default_nettype wire

// ### lpi_core.sv
// Pin-level interface of a low-power DDR memory: command, address, mask, data.
// Assumes core_clk is the rising crossing of the differential clock pair and
// that a half-rate strobe pair is formed from it for the two data beats.
`timescale 1ns/10ps
`default_nettype none
module lpi_core
  import lpi_pkg::*;
#(
  parameter int BYTES = 2,
  parameter int COL_W = 10,
  parameter int ROW_W = 13,
  parameter int DEPTH_WORDS = 64
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic [LPI_ADDR_W-1:0] addr,
  input wire logic [BYTES-1:0] byte_write_mask_rise,
  input wire logic [BYTES-1:0] byte_write_mask_fall,
  input wire logic [8*BYTES-1:0] data_in_rise,
  input wire logic [8*BYTES-1:0] data_in_fall,
  output logic [8*BYTES-1:0] data_out_rise,
  output logic [8*BYTES-1:0] data_out_fall,
  output logic data_oe,
  output logic [BYTES-1:0] strobe_out,
  output logic strobe_oe,
  output logic [LPI_ADDR_W-1:0] mode_reg0,
  output logic [LPI_ADDR_W-1:0] mode_reg1,
  output logic self_refresh
);
  localparam int DW = 8 * BYTES;
  localparam int IW = $clog2(DEPTH_WORDS);
  localparam int FW = 2 * DW;
  localparam int QW = FW + 2 * BYTES;

  // ----------------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------------
  logic [3:0] cmd;
  lpi_decode u_dec (
    .chip_select_n(chip_select_n),
    .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n),
    .write_strobe_n(write_strobe_n),
    .cmd(cmd)
  );
  wire [LPI_BANK_W-1:0] bank = {bank_select_bit1, bank_select_bit0};
  // Clock enable gates every command but self refresh entry; sampled on the rising crossing.
  wire active = clock_enable && !self_refresh;
  wire is_act = active && cmd == LPI_CMD_ACT;
  wire is_wr = active && cmd == LPI_CMD_WR;
  wire is_rd = active && cmd == LPI_CMD_RD;
  wire is_pre = active && cmd == LPI_CMD_PRE;
  wire is_mrs = active && cmd == LPI_CMD_MRS;
  // Self refresh entry is a refresh command taken while clock enable is low, so it bypasses the gate above.
  wire is_sr = !clock_enable && !self_refresh && cmd == LPI_CMD_REF;

  // ----------------------------------------------------------------------------
  // Bank rows and storage
  // ----------------------------------------------------------------------------
  logic [ROW_W-1:0] open_row_reg [4];
  logic [3:0] row_open_reg;
  logic [7:0] mem_reg [DEPTH_WORDS][2*BYTES];
  lpi_state_type state_reg;
  logic [1:0] beat_reg;
  logic [LPI_BANK_W-1:0] burst_bank_reg;
  logic [COL_W-1:0] burst_col_reg;
  logic burst_ap_reg;
  wire [IW-1:0] idx = IW'({burst_bank_reg, open_row_reg[burst_bank_reg], burst_col_reg} + beat_reg);
  wire burst_last = (beat_reg == 2'(LPI_BURST_LEN/2 - 1));

  // Write beats pass through the FIFO so storage stalls rather than drops.
  wire [QW-1:0] fifo_in = {byte_write_mask_fall, byte_write_mask_rise, data_in_fall, data_in_rise};
  wire fifo_in_valid = (state_reg == LPI_ST_WRITE);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [QW-1:0] fifo_out;
  lpi_fifo #(.WIDTH(QW), .DEPTH(LPI_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out)
  );
  logic [IW-1:0] wq_idx_reg [LPI_FIFO_DEPTH];
  logic [2:0] wq_wr_reg;
  logic [2:0] wq_rd_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      row_open_reg <= '0;
      for (int b = 0; b < 4; b++) open_row_reg[b] <= '0;
    end else begin
      if (is_pre) row_open_reg[bank] <= 1'b0;
      // Auto precharge closes the bank once the burst has run out.
      if (state_reg != LPI_ST_IDLE && burst_last && burst_ap_reg) row_open_reg[burst_bank_reg] <= 1'b0;
      // Activate stands last so that opening a row wins over a close in the same cycle.
      if (is_act) begin
        open_row_reg[bank] <= addr[ROW_W-1:0];
        row_open_reg[bank] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= LPI_ST_IDLE;
      beat_reg <= '0;
      burst_bank_reg <= '0;
      burst_col_reg <= '0;
      burst_ap_reg <= 1'b0;
    end else begin
      case (state_reg)
        LPI_ST_IDLE: begin
          beat_reg <= '0;
          if ((is_wr || is_rd) && row_open_reg[bank]) begin
            burst_bank_reg <= bank;
            burst_col_reg <= addr[COL_W-1:0];
            burst_ap_reg <= addr[LPI_AP_BIT];
            state_reg <= is_wr ? LPI_ST_WRITE : LPI_ST_READ;
          end
        end
        LPI_ST_WRITE, LPI_ST_READ: begin
          if (fifo_in_ready || state_reg == LPI_ST_READ) begin
            beat_reg <= beat_reg + 2'd1;
            if (burst_last) state_reg <= LPI_ST_IDLE;
          end
        end
        default: state_reg <= LPI_ST_IDLE;
      endcase
    end
  end

  // Write-index queue runs in step with the FIFO.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wq_wr_reg <= '0;
      wq_rd_reg <= '0;
    end else begin
      if (fifo_in_valid && fifo_in_ready) wq_wr_reg <= wq_wr_reg + 3'd1;
      if (fifo_out_valid) wq_rd_reg <= wq_rd_reg + 3'd1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (fifo_in_valid && fifo_in_ready) wq_idx_reg[wq_wr_reg] <= idx;
  end

  // ----------------------------------------------------------------------------
  // Masked storage: each word holds the rising beat then the falling beat
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (fifo_out_valid) begin
      for (int l = 0; l < 2*BYTES; l++) begin
        // Lane l pairs with mask bit l; a high mask keeps the old byte.
        if (!fifo_out[FW + l]) mem_reg[wq_idx_reg[wq_rd_reg]][l] <= fifo_out[8*l +: 8];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read path: data and strobe driven only while a read burst is out
  // ----------------------------------------------------------------------------
  logic [DW-1:0] rise_next;
  logic [DW-1:0] fall_next;
  always_comb begin
    rise_next = '0;
    fall_next = '0;
    for (int l = 0; l < BYTES; l++) begin
      rise_next[8*l +: 8] = mem_reg[idx][l];
      fall_next[8*l +: 8] = mem_reg[idx][BYTES + l];
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out_rise <= '0;
      data_out_fall <= '0;
      data_oe <= 1'b0;
      strobe_out <= '0;
      strobe_oe <= 1'b0;
    end else begin
      data_out_rise <= rise_next;
      data_out_fall <= fall_next;
      data_oe <= (state_reg == LPI_ST_READ);
      strobe_oe <= (state_reg == LPI_ST_READ);
      // Strobe high on the rising beat, edge aligned with data.
      strobe_out <= {BYTES{state_reg == LPI_ST_READ}};
    end
  end

  // ----------------------------------------------------------------------------
  // Mode registers and self refresh
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg0 <= '0;
      mode_reg1 <= '0;
      self_refresh <= 1'b0;
    end else begin
      if (is_mrs && bank == 2'b00) mode_reg0 <= addr;
      if (is_mrs && bank == 2'b10) mode_reg1 <= addr;
      // Exit honours clock enable without waiting for a command.
      if (self_refresh && clock_enable) self_refresh <= 1'b0;
      else if (is_sr) self_refresh <= 1'b1;
    end
  end

  // every register above runs on core_clk, the rising crossing.
  property p_no_drive_idle;
    @(posedge core_clk) disable iff (!reset_n)
      $past(state_reg) != LPI_ST_READ |-> !data_oe;
  endproperty
  a_no_drive_idle: assert property (p_no_drive_idle) else $error("data driven outside read");
  property p_deselect;
    @(posedge core_clk) disable iff (!reset_n)
      chip_select_n && state_reg == LPI_ST_IDLE |=> state_reg == LPI_ST_IDLE;
  endproperty
  a_deselect: assert property (p_deselect) else $error("command taken while deselected");
  property p_act;
    @(posedge core_clk) disable iff (!reset_n)
      is_act |=> open_row_reg[$past(bank)] == $past(addr[ROW_W-1:0]);
  endproperty
  a_act: assert property (p_act) else $error("row not latched");
  property p_mrs;
    @(posedge core_clk) disable iff (!reset_n)
      is_mrs && bank == 2'b00 |=> mode_reg0 == $past(addr);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode opcode lost");
  property p_burst;
    @(posedge core_clk) disable iff (!reset_n)
      state_reg == LPI_ST_IDLE && is_rd && row_open_reg[bank] |=> state_reg == LPI_ST_READ [*2] ##1 state_reg == LPI_ST_IDLE;
  endproperty
  a_burst: assert property (p_burst) else $error("read burst length wrong");
  property p_strobe;
    @(posedge core_clk) disable iff (!reset_n) strobe_oe == data_oe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not aligned");
  property p_cmd;
    @(posedge core_clk) disable iff (!reset_n)
      !chip_select_n |-> cmd == {1'b0, row_strobe_n, col_strobe_n, write_strobe_n};
  endproperty
  a_cmd: assert property (p_cmd) else $error("command code wrong");
  property p_sr_exit;
    @(posedge core_clk) disable iff (!reset_n) self_refresh && clock_enable |=> !self_refresh;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit missed");
  property p_sr_entry;
    @(posedge core_clk) disable iff (!reset_n)
      !clock_enable && !self_refresh && !chip_select_n && !row_strobe_n && !col_strobe_n && write_strobe_n
      |=> self_refresh;
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("self refresh entry missed");
  c_self_refresh: cover property (@(posedge core_clk) $rose(self_refresh));
  c_write: cover property (@(posedge core_clk) state_reg == LPI_ST_WRITE);
  c_read: cover property (@(posedge core_clk) data_oe);
  c_mrs: cover property (@(posedge core_clk) is_mrs);
endmodule
`default_nettype wire

// ### lpi_ctrl_model.sv
// Controller model: drives command, address, masks and write beats.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module lpi_ctrl_model
  import lpi_pkg::*;
#(
  parameter int BYTES = 2
) (
  input wire logic core_clk,
  output logic clock_enable,
  output logic chip_select_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_strobe_n,
  output logic bank_select_bit0,
  output logic bank_select_bit1,
  output logic [LPI_ADDR_W-1:0] addr,
  output logic [BYTES-1:0] byte_write_mask_rise,
  output logic [BYTES-1:0] byte_write_mask_fall,
  output logic [8*BYTES-1:0] data_in_rise,
  output logic [8*BYTES-1:0] data_in_fall
);
  initial begin
    clock_enable = 1'b1;
    drive_idle(32'h0);
  end
  // Released lines carry a changing pattern, so a stale beat never looks valid.
  task automatic drive_idle(input logic [31:0] n);
    chip_select_n = 1'b1;
    {row_strobe_n, col_strobe_n, write_strobe_n} = n[2:0];
    {bank_select_bit1, bank_select_bit0} = n[4:3];
    addr = n[LPI_ADDR_W+4:5];
    byte_write_mask_rise = {BYTES{n[18]}};
    byte_write_mask_fall = {BYTES{n[19]}};
    data_in_rise = {BYTES{n[31:24]}};
    data_in_fall = {BYTES{n[23:16]}};
  endtask
  task automatic step();
    @(posedge core_clk);
    #2;
  endtask
  task automatic idle(input logic [31:0] n);
    drive_idle(n);
    step();
  endtask
  task automatic issue(input logic [3:0] cmd, input logic [1:0] bank, input logic [LPI_ADDR_W-1:0] a,
                       input logic cs_n, input logic [31:0] n);
    drive_idle(n);
    chip_select_n = cs_n;
    {row_strobe_n, col_strobe_n, write_strobe_n} = cmd[2:0];
    {bank_select_bit1, bank_select_bit0} = bank;
    addr = a;
    step();
  endtask
  task automatic beat(input logic [8*BYTES-1:0] r, f, input logic [BYTES-1:0] mr, mf, input logic [31:0] n);
    drive_idle(n);
    data_in_rise = r;
    data_in_fall = f;
    byte_write_mask_rise = mr;
    byte_write_mask_fall = mf;
    step();
  endtask
  task automatic set_cke(input logic v);
    clock_enable = v;
  endtask
endmodule
`default_nettype wire

// ### lpi_core_tb.sv
// Self-checking bench of the memory pin interface and its buffer.
// Assumes the controller model owns every command-side input of the core.
`timescale 1ns/10ps
`default_nettype none
module lpi_core_tb;
  import lpi_pkg::*;
  localparam int BYTES = 2;
  localparam int DW = 8 * BYTES;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clock_enable, chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n;
  logic bank_select_bit0, bank_select_bit1, data_oe, strobe_oe, self_refresh;
  logic [LPI_ADDR_W-1:0] addr, mode_reg0, mode_reg1;
  logic [BYTES-1:0] byte_write_mask_rise, byte_write_mask_fall, strobe_out;
  logic [DW-1:0] data_in_rise, data_in_fall, data_out_rise, data_out_fall;
  logic [DW-1:0] wd [4];
  logic [DW-1:0] cur [4];
  logic [BYTES-1:0] wm [4];
  logic [LPI_ADDR_W-1:0] exp_mr [2] = '{default: '0};
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h8A5C;
  lpi_core #(.BYTES(BYTES)) i_lpi_core (.*);
  lpi_ctrl_model #(.BYTES(BYTES)) i_lpi_ctrl_model (.*);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, nw, input logic [BYTES-1:0] m);
    logic [DW-1:0] res;
    res = nw;
    for (int l = 0; l < BYTES; l++) begin
      if (m[l]) begin
        res[8*l +: 8] = old[8*l +: 8];
      end
    end
    return res;
  endfunction
  task automatic check(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) i_lpi_ctrl_model.idle(rnd());
  endtask
  task automatic fill(input int mode);
    logic [31:0] r;
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      wd[k] = r[DW-1:0];
      wm[k] = (mode == 0) ? '0 : (mode == 2) ? '1 : r[DW+BYTES-1:DW];
    end
  endtask
  // Gap is the idle time after the burst; zero lets the next command chase the write buffer.
  task automatic wr(input logic [1:0] bank, input logic [LPI_ADDR_W-1:0] a, input int gap);
    i_lpi_ctrl_model.issue(LPI_CMD_WR, bank, a, 1'b0, rnd());
    for (int k = 0; k < 4; k += 2) begin
      check(data_oe, 1'b0);
      i_lpi_ctrl_model.beat(wd[k], wd[k+1], wm[k], wm[k+1], rnd());
      cur[k] = merge(cur[k], wd[k], wm[k]);
      cur[k+1] = merge(cur[k+1], wd[k+1], wm[k+1]);
    end
    tick(gap);
  endtask
  task automatic rd(input logic [1:0] bank, input logic [LPI_ADDR_W-1:0] a, input logic open);
    int k;
    i_lpi_ctrl_model.issue(LPI_CMD_RD, bank, a, 1'b0, rnd());
    k = 0;
    while (data_oe !== 1'b1 && k < 6) begin
      tick(1);
      k++;
    end
    check(data_oe, open);
    if (data_oe === 1'b1) begin
      for (int b = 0; b < 4; b += 2) begin
        check(strobe_oe, 1'b1);
        check(strobe_out, {BYTES{1'b1}});
        check(data_out_rise, cur[b]);
        check(data_out_fall, cur[b+1]);
        tick(1);
      end
      check(data_oe, 1'b0);
      check({strobe_oe, strobe_out}, '0);
    end
    tick(2);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [1:0] bk;
    logic [LPI_ADDR_W-1:0] col;
    repeat (2) @(posedge core_clk);
    #2;
    check({data_oe, strobe_oe, self_refresh, data_out_rise}, '0);
    check({mode_reg0, mode_reg1}, '0);
    reset_n = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      bk = i[0] ? 2'b10 : 2'b00;
      i_lpi_ctrl_model.issue(LPI_CMD_MRS, bk, r[LPI_ADDR_W-1:0], i[1] & ~i[2], rnd());
      if (!(i[1] & ~i[2])) exp_mr[i[0]] = r[LPI_ADDR_W-1:0];
      i_lpi_ctrl_model.issue(i[0] ? LPI_CMD_NOP : LPI_CMD_BST, 2'b00, '0, 1'b0, rnd());
      tick(1);
      check(mode_reg0, exp_mr[0]);
      check(mode_reg1, exp_mr[1]);
    end
    $display("test mode registers done");
    for (int t = 0; t < 6; t++) begin
      r = rnd();
      bk = r[1:0];
      col = {3'b000, r[27:20], 2'b00};
      i_lpi_ctrl_model.issue(LPI_CMD_ACT, bk, r[14:2], 1'b0, rnd());
      fill(0);
      wr(bk, col, 6);
      rd(bk, col, 1'b1);
      fill(t == 0 ? 2 : 1);
      wr(bk, col, 6);
      rd(bk, col | (t[0] ? 13'h0400 : 13'h0000), 1'b1);
      if (!t[0]) i_lpi_ctrl_model.issue(LPI_CMD_PRE, bk, '0, 1'b0, rnd());
      rd(bk, col, 1'b0);
    end
    $display("test data bursts done");
    i_lpi_ctrl_model.set_cke(1'b0);
    i_lpi_ctrl_model.issue(LPI_CMD_REF, 2'b00, '0, 1'b0, rnd());
    tick(2);
    check(self_refresh, 1'b1);
    i_lpi_ctrl_model.issue(LPI_CMD_MRS, 2'b00, 13'h0155, 1'b0, rnd());
    i_lpi_ctrl_model.set_cke(1'b1);
    tick(2);
    check(self_refresh, 1'b0);
    check(mode_reg0, exp_mr[0]);
    $display("test self refresh done");
    // Back-to-back writes and a read with no drain time test the write buffer's order and latency.
    for (int n = 0; n < 3; n++) begin
      r = rnd();
      bk = r[1:0];
      col = {3'b000, r[27:20], 2'b00};
      i_lpi_ctrl_model.issue(LPI_CMD_ACT, bk, r[14:2], 1'b0, rnd());
      fill(0);
      wr(bk, col, 0);
      fill(1);
      wr(bk, col, 0);
      rd(bk, col, 1'b1);
      check({data_oe, strobe_oe}, 2'b00);
    end
    $display("test buffer done");
    conclude();
  end
  initial begin
    #(20 * 4000);
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
